// ===== rtl/mmu_perm_pkg.sv
package mmu_perm_pkg;

  // Privilege levels
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERN = 2'h1;
  localparam logic [1:0] LVL_HYP  = 2'h2;
  localparam logic [1:0] LVL_MON  = 2'h3;

  // Permission field encodings
  localparam logic [1:0] AP_PRIV_RW = 2'h0;
  localparam logic [1:0] AP_ALL_RW  = 2'h1;
  localparam logic [1:0] AP_PRIV_RO = 2'h2;
  localparam logic [1:0] AP_ALL_RO  = 2'h3;

  // Descriptor field positions
  localparam int DESC_NS_POS    = 5;
  localparam int DESC_AP_LO     = 6;
  localparam int DESC_AF_POS    = 10;
  localparam int DESC_SW_LO     = 55;
  localparam int DESC_SW_HI     = 58;
  localparam int DESC_PXN_POS   = 53;
  localparam int DESC_UXN_POS   = 54;
  localparam int DESC_OA_LO     = 12;
  localparam int DESC_OA_HI     = 47;

  // Register bus map (byte addresses, byte address = 4 * word index)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_S2CTRL   = 8'h04;
  localparam logic [7:0] REG_MONCTRL  = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_FAULTADR = 8'h10;
  localparam logic [7:0] REG_HYPCTRL  = 8'h14;
  localparam logic [7:0] REG_KERNCTRL = 8'h18;

  // Control register bit positions
  localparam int CTRL_S2EN_POS   = 0;
  localparam int CTRL_KWXN_POS   = 1;
  localparam int CTRL_HWXN_POS   = 2;
  localparam int CTRL_MWXN_POS   = 3;
  localparam int CTRL_USER_WRITE_IMPLIES_NOEXEC_POS   = 4;
  localparam int CTRL_CIF_POS    = 5;
  // Size/granule/start-level fields (same layout in stage-two, kernel, hyp and monitor control regs)
  localparam int TSZ_LO = 0;
  localparam int TG_LO  = 14;
  localparam int SL_LO  = 6;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TCR_RESET  = 32'h0000_0010;

  // Fault codes
  localparam logic [1:0] FLT_NONE  = 2'h0;
  localparam logic [1:0] FLT_TRANS = 2'h1;
  localparam logic [1:0] FLT_PERM  = 2'h2;

endpackage : mmu_perm_pkg

// ===== rtl/mmu_permission_security_check.sv
`timescale 1ns/1ps
module mmu_permission_security_check (
  input  wire logic        core_clk,       // Core clock, 250 MHz
  input  wire logic        rst_b,          // Synchronous reset, active low
  input  wire logic [7:0]  regAddr,        // Register byte address
  input  wire logic [31:0] regWdata,       // Register write data
  input  wire logic        regWr,          // Register write strobe
  input  wire logic        regRd,          // Register read strobe
  output logic      [31:0] regRdata,       // Read data, cycle after strobe
  input  wire logic        reqValid,       // Access request valid
  input  wire logic [47:0] reqAddr,        // Input address of access
  input  wire logic [1:0]  reqLevel,       // Current exception level
  input  wire logic        reqWrite,       // Access is a write
  input  wire logic        reqFetch,       // Access is instruction fetch
  input  wire logic        reqSecure,      // Core is in secure state
  input  wire logic        reqNarrow,      // Core is in 32-bit state
  input  wire logic [63:0] s1Desc,         // Stage-one block descriptor
  input  wire logic        s1TableNs,      // Table-level non-secure bit
  input  wire logic [63:0] s2Desc,         // Stage-two block descriptor
  output logic             rspValid,       // Result valid, follows reqValid one cycle later
  output logic             rspGrant,       // Access may proceed
  output logic      [1:0]  rspFault,       // Fault code
  output logic      [47:0] rspPhysAddr,    // Final output address
  output logic             rspNonSecure,   // Output in non-secure space
  output logic             rspUseStage2,   // Stage two applied
  output logic      [1:0]  rspGranule,     // Granule selected
  output logic      [1:0]  rspStartLevel,  // Start level selected
  output logic      [47:0] rspTableBase,   // Table base for regime
  output logic             rspCacheNsTag   // Tag for translation cache entry
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] s2Ctrl;
    logic [31:0] hypCtrl;
    logic [31:0] monCtrl;
    logic [31:0] kernCtrl;
    logic [47:0] faultAddr;
    logic [1:0]  lastFault;
    logic [15:0] faultCount;
    logic [31:0] rdata;
    logic        vld;
    logic        grant;
    logic [1:0]  fault;
    logic [47:0] pa;
    logic        ns;
    logic        useS2;
    logic [1:0]  gran;
    logic [1:0]  startLvl;
    logic [47:0] base;
  } state_t;

  state_t st;
  state_t next_st;

  // Table bases fed by register writes
  logic [47:0] kernBase;
  logic [47:0] hypBase;
  logic [47:0] monBase;
  logic [47:0] s2Base;

  assign kernBase = {st.kernCtrl[31:16], 32'h0000_0000};
  assign hypBase  = {st.hypCtrl[31:16], 32'h0000_0000};
  assign monBase  = {st.monCtrl[31:16], 32'h0000_0000};
  assign s2Base   = {st.s2Ctrl[31:16], 32'h0000_0000};

  // Returns 1 if address beyond 2^(64-size) region
  function automatic logic outOfRange(input logic [47:0] a, input logic [5:0] ipa_size_field);
    logic [6:0] width;
    logic       bad;
    width = 7'h40 - {1'b0, ipa_size_field};
    bad = 1'b0;
    for (int i = 0; i < 48; i++)
    begin
      if (a[i] && (i >= int'(width)))
        bad = 1'b1;
    end
    return bad;
  endfunction : outOfRange

  // Read/write permission from field
  function automatic logic permOk(input logic [1:0] ap, input logic unpriv, input logic wr);
    logic ok;
    case (ap)
      mmu_perm_pkg::AP_PRIV_RW: ok = !unpriv;
      mmu_perm_pkg::AP_ALL_RW:  ok = 1'b1;
      mmu_perm_pkg::AP_PRIV_RO: ok = !unpriv && !wr;
      mmu_perm_pkg::AP_ALL_RO:  ok = !wr;
      default:                  ok = 1'b0;
    endcase
    return ok;
  endfunction : permOk

  logic        unpriv;
  logic        stage2On;
  logic [31:0] activeTcr;
  logic [1:0]  ap1;
  logic        userWritable;
  logic        privWritable;
  logic        execNever;
  logic        nsOut;
  logic        transFault;
  logic        permFault;
  logic [47:0] ipa;
  logic [47:0] finalPa;
  logic        wxnCtrl;

  always_comb
  begin
    next_st = st;
    unpriv = (reqLevel == mmu_perm_pkg::LVL_USER);
    // Stage two for non-secure user/kernel only
    stage2On = st.ctrl[mmu_perm_pkg::CTRL_S2EN_POS] && !reqSecure &&
               (reqLevel == mmu_perm_pkg::LVL_USER || reqLevel == mmu_perm_pkg::LVL_KERN);
    case (reqLevel)
      mmu_perm_pkg::LVL_HYP:  activeTcr = st.hypCtrl;
      mmu_perm_pkg::LVL_MON:  activeTcr = st.monCtrl;
      default:                activeTcr = st.kernCtrl;
    endcase
    ap1 = s1Desc[mmu_perm_pkg::DESC_AP_LO +: 2];
    userWritable = (ap1 == mmu_perm_pkg::AP_ALL_RW);
    privWritable = (ap1 == mmu_perm_pkg::AP_PRIV_RW) || (ap1 == mmu_perm_pkg::AP_ALL_RW);
    wxnCtrl = 1'b0;
    execNever = 1'b0;
    case (reqLevel)
      mmu_perm_pkg::LVL_USER:
      begin
        execNever = s1Desc[mmu_perm_pkg::DESC_UXN_POS];
        wxnCtrl = st.ctrl[mmu_perm_pkg::CTRL_KWXN_POS] && userWritable;
      end
      mmu_perm_pkg::LVL_KERN:
      begin
        execNever = s1Desc[mmu_perm_pkg::DESC_PXN_POS];
        wxnCtrl = (st.ctrl[mmu_perm_pkg::CTRL_KWXN_POS] && privWritable) ||
                  (reqNarrow && st.ctrl[mmu_perm_pkg::CTRL_USER_WRITE_IMPLIES_NOEXEC_POS] && userWritable);
      end
      mmu_perm_pkg::LVL_HYP:
      begin
        execNever = s1Desc[mmu_perm_pkg::DESC_PXN_POS];
        wxnCtrl = st.ctrl[mmu_perm_pkg::CTRL_HWXN_POS] && !ap1[1];
      end
      default:
      begin
        execNever = s1Desc[mmu_perm_pkg::DESC_PXN_POS];
        wxnCtrl = st.ctrl[mmu_perm_pkg::CTRL_MWXN_POS] && !ap1[1];
      end
    endcase
    if (stage2On)
      execNever = execNever || s2Desc[mmu_perm_pkg::DESC_UXN_POS];
    execNever = execNever || wxnCtrl;
    // Security space selection; bits 58:55 never read
    nsOut = reqSecure ? (s1Desc[mmu_perm_pkg::DESC_NS_POS] || s1TableNs) : 1'b1;
    ipa = {s1Desc[mmu_perm_pkg::DESC_OA_HI:mmu_perm_pkg::DESC_OA_LO], reqAddr[11:0]};
    finalPa = stage2On ? {s2Desc[mmu_perm_pkg::DESC_OA_HI:mmu_perm_pkg::DESC_OA_LO], ipa[11:0]} : ipa;
    transFault = outOfRange(reqAddr, activeTcr[mmu_perm_pkg::TSZ_LO +: 6]) ||
                 (stage2On && outOfRange(ipa, st.s2Ctrl[mmu_perm_pkg::TSZ_LO +: 6])) ||
                 !s1Desc[mmu_perm_pkg::DESC_AF_POS] ||
                 (stage2On && !s2Desc[mmu_perm_pkg::DESC_AF_POS]);
    if (reqFetch)
      permFault = execNever ||
                  (reqSecure && st.ctrl[mmu_perm_pkg::CTRL_CIF_POS] && nsOut) ||
                  !permOk(ap1, unpriv && (reqLevel == mmu_perm_pkg::LVL_USER), 1'b0);
    else
      permFault = !permOk(ap1, unpriv, reqWrite) ||
                  (stage2On && !permOk(s2Desc[mmu_perm_pkg::DESC_AP_LO +: 2], 1'b0, reqWrite));

    next_st.vld = reqValid;
    next_st.grant = reqValid && !transFault && !permFault;
    next_st.fault = !reqValid ? mmu_perm_pkg::FLT_NONE :
                    transFault ? mmu_perm_pkg::FLT_TRANS :
                    permFault ? mmu_perm_pkg::FLT_PERM : mmu_perm_pkg::FLT_NONE;
    next_st.pa = (reqValid && !transFault && !permFault) ? finalPa : 48'h0000_0000_0000;
    next_st.ns = nsOut;
    next_st.useS2 = stage2On;
    next_st.gran = stage2On ? st.s2Ctrl[mmu_perm_pkg::TG_LO +: 2] : activeTcr[mmu_perm_pkg::TG_LO +: 2];
    next_st.startLvl = stage2On ? st.s2Ctrl[mmu_perm_pkg::SL_LO +: 2] : activeTcr[mmu_perm_pkg::SL_LO +: 2];
    case (reqLevel)
      mmu_perm_pkg::LVL_HYP: next_st.base = hypBase;
      mmu_perm_pkg::LVL_MON: next_st.base = monBase;
      default:               next_st.base = stage2On ? s2Base : kernBase;
    endcase
    if (reqValid && (transFault || permFault))
    begin
      next_st.faultAddr = reqAddr;
      next_st.lastFault = transFault ? mmu_perm_pkg::FLT_TRANS : mmu_perm_pkg::FLT_PERM;
      next_st.faultCount = st.faultCount + 16'h0001;
    end

    if (regWr)
    begin
      case (regAddr)
        mmu_perm_pkg::REG_CTRL:     next_st.ctrl = regWdata;
        mmu_perm_pkg::REG_S2CTRL:   next_st.s2Ctrl = regWdata;
        mmu_perm_pkg::REG_MONCTRL:  next_st.monCtrl = regWdata;
        mmu_perm_pkg::REG_HYPCTRL:  next_st.hypCtrl = regWdata;
        mmu_perm_pkg::REG_KERNCTRL: next_st.kernCtrl = regWdata;
        default:                    next_st.ctrl = st.ctrl;
      endcase
    end
    next_st.rdata = 32'h0000_0000;
    if (regRd)
    begin
      case (regAddr)
        mmu_perm_pkg::REG_CTRL:     next_st.rdata = st.ctrl;
        mmu_perm_pkg::REG_S2CTRL:   next_st.rdata = st.s2Ctrl;
        mmu_perm_pkg::REG_MONCTRL:  next_st.rdata = st.monCtrl;
        mmu_perm_pkg::REG_HYPCTRL:  next_st.rdata = st.hypCtrl;
        mmu_perm_pkg::REG_KERNCTRL: next_st.rdata = st.kernCtrl;
        mmu_perm_pkg::REG_STATUS:   next_st.rdata = {14'h0000, st.lastFault, st.faultCount};
        mmu_perm_pkg::REG_FAULTADR: next_st.rdata = st.faultAddr[31:0];
        default:                    next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.ctrl <= mmu_perm_pkg::CTRL_RESET;
      st.s2Ctrl <= mmu_perm_pkg::TCR_RESET;
      st.hypCtrl <= mmu_perm_pkg::TCR_RESET;
      st.monCtrl <= mmu_perm_pkg::TCR_RESET;
      st.kernCtrl <= mmu_perm_pkg::TCR_RESET;
      st.ns <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign regRdata      = st.rdata;
  assign rspValid      = st.vld;
  assign rspGrant      = st.grant;
  assign rspFault      = st.fault;
  assign rspPhysAddr   = st.pa;
  assign rspNonSecure  = st.ns;
  assign rspUseStage2  = st.useS2;
  assign rspGranule    = st.gran;
  assign rspStartLevel = st.startLvl;
  assign rspTableBase  = st.base;
  assign rspCacheNsTag = st.ns;

endmodule : mmu_permission_security_check

// ===== verif/core_side_model.sv
`timescale 1ns/1ps
module core_side_model (
  input  wire logic        core_clk,   // Core clock
  output logic             reqValid,   // Request valid
  output logic      [47:0] reqAddr,    // Input address
  output logic      [1:0]  reqLevel,   // Level
  output logic             reqWrite,   // Write access
  output logic             reqFetch,   // Fetch access
  output logic             reqSecure,  // Secure state
  output logic             reqNarrow,  // 32-bit state
  output logic      [63:0] s1Desc,     // Stage-one descriptor
  output logic             s1TableNs,  // Table non-secure bit
  output logic      [63:0] s2Desc      // Stage-two descriptor
);
  initial
  begin
    {reqValid, reqAddr, reqLevel, reqWrite, reqFetch, reqSecure, reqNarrow} = '0;
    {s1Desc, s1TableNs, s2Desc} = '0;
  end
  task automatic issue(input logic [1:0] lv, input logic [3:0] k, input logic [47:0] a, input logic [63:0] d,
                       input logic tns);
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqLevel <= lv;
    {reqWrite, reqFetch, reqSecure, reqNarrow} <= k;
    s1Desc <= d;
    s1TableNs <= tns;
    // Walker hands back an open stage-two block onto the same output address
    s2Desc <= {16'h0, d[47:12], 12'h440};
  endtask : issue
  task automatic idle;
    @(posedge core_clk);
    reqValid <= 1'b0;
    // Stale walk results are not held
    reqAddr <= ~reqAddr;
    s1Desc <= ~s1Desc;
    s2Desc <= ~s2Desc;
  endtask : idle
endmodule : core_side_model

// ===== verif/mmu_perm_check_props.sv
`timescale 1ns/1ps
module mmu_perm_check_props (
  input wire logic        core_clk,       // Core clock
  input wire logic        rst_b,          // Sync reset, active low
  input wire logic        reqValid,       // Request valid
  input wire logic [1:0]  reqLevel,       // Request level
  input wire logic        reqWrite,       // Write access
  input wire logic        reqFetch,       // Fetch access
  input wire logic        reqSecure,      // Secure state
  input wire logic [63:0] s1Desc,         // Stage-one descriptor
  input wire logic        s1TableNs,      // Table non-secure bit
  input wire logic        rspValid,       // Result valid
  input wire logic        rspGrant,       // Access allowed
  input wire logic [1:0]  rspFault,       // Fault code
  input wire logic        rspNonSecure,   // Output space
  input wire logic        rspUseStage2,   // Stage two applied
  input wire logic        rspCacheNsTag   // Cache entry tag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_rsp_next: assert property (reqValid |=> rspValid) else $error("result missing");
  a_rsp_only: assert property (!reqValid |=> !rspValid) else $error("result without request");
  a_grant_fault: assert property (rspValid |-> rspGrant == (rspFault == mmu_perm_pkg::FLT_NONE))
    else $error("grant and fault disagree");
  a_ns_world: assert property (reqValid && !reqSecure |=> rspNonSecure) else $error("normal world secure");
  a_sec_select: assert property (reqValid && reqSecure |=> !rspGrant || rspNonSecure == $past(s1Desc[5] | s1TableNs))
    else $error("secure space select wrong");
  a_stage2_world: assert property (reqValid && (reqSecure || reqLevel[1]) |=> !rspUseStage2)
    else $error("stage two misapplied");
  a_unused_flag: assert property (reqValid && !s1Desc[10] |=> rspFault == mmu_perm_pkg::FLT_TRANS)
    else $error("unused flag not faulted");
  a_ro_write: assert property (reqValid && reqWrite && s1Desc[7] |=> !rspGrant) else $error("read-only written");
  a_user_xn: assert property (reqValid && reqFetch && reqLevel == 2'h0 && s1Desc[54] |=> !rspGrant)
    else $error("user no-exec fetched");
  a_priv_xn: assert property (reqValid && reqFetch && reqLevel == 2'h1 && s1Desc[53] |=> !rspGrant)
    else $error("priv no-exec fetched");
  a_tag_match: assert property (rspCacheNsTag == rspNonSecure) else $error("cache tag differs");

  c_perm_fault: cover property (rspValid && rspFault == mmu_perm_pkg::FLT_PERM);
  c_trans_fault: cover property (rspValid && rspFault == mmu_perm_pkg::FLT_TRANS);
  c_stage2: cover property (rspValid && rspUseStage2 && rspGrant);
endmodule : mmu_perm_check_props

bind mmu_permission_security_check mmu_perm_check_props u_mmu_perm_check_props (.core_clk, .rst_b, .reqValid,
  .reqLevel, .reqWrite, .reqFetch, .reqSecure, .s1Desc, .s1TableNs, .rspValid, .rspGrant, .rspFault,
  .rspNonSecure, .rspUseStage2, .rspCacheNsTag);

// ===== verif/test_mmu_permission_security_check.sv
`timescale 1ns/1ps
module test_mmu_permission_security_check;
  localparam logic [1:0] N = mmu_perm_pkg::FLT_NONE;
  localparam logic [1:0] T = mmu_perm_pkg::FLT_TRANS;
  localparam logic [1:0] P = mmu_perm_pkg::FLT_PERM;
  logic        core_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, lastRd = 1'b0, s2en = 1'b0, nar = 1'b0;
  logic [7:0]  regAddr  = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, seed = 32'h21;
  logic        reqValid, reqWrite, reqFetch, reqSecure, reqNarrow, s1TableNs, rspValid, rspGrant;
  logic        rspNonSecure, rspUseStage2, rspCacheNsTag;
  logic [1:0]  reqLevel, rspFault, rspGranule, rspStartLevel;
  logic [47:0] reqAddr, rspPhysAddr, rspTableBase;
  logic [63:0] s1Desc, s2Desc;
  logic [51:0] rspQ[$];
  logic [31:0] regQ[$];
  int          errors = 0, samples_checked = 0;

  always #2 core_clk = ~core_clk;

  mmu_permission_security_check u_mmu_permission_security_check (.core_clk, .rst_b, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .reqValid, .reqAddr, .reqLevel, .reqWrite, .reqFetch, .reqSecure, .reqNarrow, .s1Desc,
    .s1TableNs, .s2Desc, .rspValid, .rspGrant, .rspFault, .rspPhysAddr, .rspNonSecure, .rspUseStage2,
    .rspGranule, .rspStartLevel, .rspTableBase, .rspCacheNsTag);
  core_side_model u_core_side_model (.core_clk, .reqValid, .reqAddr, .reqLevel, .reqWrite, .reqFetch, .reqSecure,
    .reqNarrow, .s1Desc, .s1TableNs, .s2Desc);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge core_clk);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWdata <= d;
    if (r)
      regQ.push_back(e);
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d, 32'h0);
    bus(1'b0, 1'b0, a, ~d, 32'h0);
    // Controls settle before new traffic
    repeat (2) @(posedge core_clk);
  endtask : wreg
  task automatic chk(input logic [1:0] lv, ap, ef, input logic fe = 0, wr = 0, sec = 0, nsb = 0, tns = 0,
                     input logic [1:0] xn = 0, input logic af = 1, input logic [47:0] va = 48'h0,
                     input logic [35:0] oa = 36'h0_0001_2345);
    logic [31:0] r;
    logic [47:0] a;
    logic [63:0] d;
    r = rnd();
    a = {va[47:12], r[11:0]};
    // Software-owned bits get random values
    d = {5'h0, r[15:12], xn, 5'h0, oa, 1'b0, af, 2'h0, ap, nsb, 5'h0};
    u_core_side_model.issue(lv, {wr, fe, sec, nar}, a, d, tns);
    rspQ.push_back({ef, sec ? (nsb | tns) : 1'b1, s2en & ~sec & ~lv[1], ef == N ? {oa, a[11:0]} : 48'h0});
    // One request per call; a held request would answer again with no note queued
    u_core_side_model.idle();
  endtask : chk
  task automatic cmp_rsp(input logic [51:0] e);
    samples_checked++;
    if (rspFault !== e[51:50] || rspPhysAddr !== e[47:0] || (e[51:50] == N && {rspNonSecure, rspUseStage2} !== e[49:48]))
    begin
      errors++;
      $display("BAD %0t check result %h", $time, e);
    end
  endtask : cmp_rsp
  task automatic cmp_reg(input logic [31:0] e);
    samples_checked++;
    if (regRdata !== e)
    begin
      errors++;
      $display("BAD %0t read data %h", $time, regRdata);
    end
  endtask : cmp_reg
  task automatic wrap_up;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) lastRd <= regRd;
  always @(negedge core_clk)
  begin
    if (lastRd)
      cmp_reg(regQ.pop_front());
    if (rspValid === 1'b1)
      cmp_rsp(rspQ.pop_front());
  end

  initial
  begin
    #40000;
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    bus(1'b0, 1'b1, mmu_perm_pkg::REG_CTRL, 32'h0, mmu_perm_pkg::CTRL_RESET);
    bus(1'b0, 1'b1, mmu_perm_pkg::REG_S2CTRL, 32'h0, mmu_perm_pkg::TCR_RESET);
    bus(1'b0, 1'b1, mmu_perm_pkg::REG_KERNCTRL, 32'h0, mmu_perm_pkg::TCR_RESET);
    bus(1'b0, 1'b1, 8'h1C, 32'h0, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    for (int l = 0; l < 3; l++)
      for (int p = 0; p < 4; p++)
        for (int w = 0; w < 2; w++)
          chk(l[1:0], p[1:0], ((l == 0 && !p[0]) || (w == 1 && p[1])) ? P : N, 1'b0, w[0]);
    chk(2'h0, 2'h0, T, .af(1'b0));
    chk(2'h0, 2'h1, P, 1'b1, .xn(2'h2));
    chk(2'h0, 2'h1, N, 1'b1, .xn(2'h1));
    chk(2'h1, 2'h1, P, 1'b1, .xn(2'h1));
    chk(2'h1, 2'h1, N, 1'b1, .xn(2'h2));
    wreg(mmu_perm_pkg::REG_CTRL, 32'h2);
    chk(2'h0, 2'h1, P, 1'b1);
    chk(2'h1, 2'h1, P, 1'b1);
    chk(2'h1, 2'h0, P, 1'b1);
    chk(2'h1, 2'h3, N, 1'b1);
    wreg(mmu_perm_pkg::REG_CTRL, 32'h4);
    chk(2'h2, 2'h0, P, 1'b1);
    chk(2'h2, 2'h2, N, 1'b1);
    wreg(mmu_perm_pkg::REG_CTRL, 32'h8);
    chk(2'h3, 2'h0, P, 1'b1);
    chk(2'h2, 2'h0, N, 1'b1);
    wreg(mmu_perm_pkg::REG_CTRL, 32'h10);
    nar = 1'b1;
    chk(2'h1, 2'h1, P, 1'b1);
    nar = 1'b0;
    chk(2'h1, 2'h1, N, 1'b1);
    wreg(mmu_perm_pkg::REG_CTRL, 32'h20);
    chk(2'h1, 2'h1, P, 1'b1, .sec(1'b1), .nsb(1'b1));
    chk(2'h1, 2'h1, N, 1'b1, .sec(1'b1));
    chk(2'h1, 2'h1, N, 1'b0, .sec(1'b1), .tns(1'b1));
    chk(2'h1, 2'h1, N, 1'b0, .nsb(1'b0), .tns(1'b0));
    wreg(mmu_perm_pkg::REG_KERNCTRL, 32'h14);
    bus(1'b0, 1'b1, mmu_perm_pkg::REG_KERNCTRL, 32'h0, 32'h14);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    chk(2'h1, 2'h1, T, .va(48'h1000_0000_0000));
    chk(2'h1, 2'h1, N, .va(48'h0800_0000_0000));
    wreg(mmu_perm_pkg::REG_S2CTRL, 32'h18);
    wreg(mmu_perm_pkg::REG_CTRL, 32'h1);
    s2en = 1'b1;
    chk(2'h1, 2'h1, T, .oa(36'h0_1000_0000));
    chk(2'h1, 2'h1, N, .sec(1'b1), .oa(36'h0_1000_0000));
    chk(2'h0, 2'h1, N);
    chk(2'h2, 2'h1, N);
    u_core_side_model.idle();
    repeat (3) @(posedge core_clk);
    wrap_up();
  end
endmodule : test_mmu_permission_security_check
